// file: ces_pkg.sv
// Shared constants and types for the instruction execution subset block.
package ces_pkg;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_OPERAND = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_FLAGS = 8'h0c;
	localparam logic [7:0] OFF_PC = 8'h10;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h14;
	localparam logic [7:0] OFF_MEM_DATA = 8'h18;
	localparam logic [7:0] OFF_DOG = 8'h1c;
	localparam logic [7:0] OFF_WAKE = 8'h20;

	// Instruction word fields.
	localparam int INSTR_OP_LSB = 0;
	localparam int INSTR_OP_W = 6;
	localparam int INSTR_BIT_LSB = 8;
	localparam int INSTR_ADDR_LSB = 16;

	// Flag register bit positions.
	localparam int FLG_CARRY = 0;
	localparam int FLG_HALF = 1;
	localparam int FLG_ZERO = 2;
	localparam int FLG_TIMEOUT = 3;
	localparam int FLG_PDOWN = 4;
	localparam int FLG_GIE = 5;
	localparam int FLG_PEND = 6;
	localparam int FLG_W = 7;

	// Status register bit positions above the working register byte.
	localparam int ST_FLAGS_LSB = 8;
	localparam int ST_BUSY = 16;
	localparam int ST_ASLEEP = 17;
	localparam int ST_ILLEGAL = 18;

	// Decimal adjust constants.
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [8:0] BCD_ADD_LO = 9'h006;
	localparam logic [8:0] BCD_ADD_HI = 9'h060;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reset values.
	localparam logic [7:0] WREG_RST = 8'h00;
	localparam logic [FLG_W-1:0] FLAGS_RST = 7'h00;

	// Operation codes, in the order of their numeric codes from zero.
	typedef enum logic [INSTR_OP_W-1:0] {
		OP_IDLE_OP, OP_CLEAR_MEM, OP_CLEAR_BIT, OP_CLEAR_WATCHDOG,
		OP_COMPLEMENT_MEM, OP_COMPLEMENT_TO_WREG, OP_BCD_ADJUST,
		OP_MINUS_ONE_MEM, OP_MINUS_ONE_TO_WREG, OP_SLEEP_ENTRY,
		OP_PLUS_ONE_MEM, OP_PLUS_ONE_TO_WREG, OP_GOTO_ADDR,
		OP_TRANSFER_MEM_TO_WREG, OP_TRANSFER_IMM_TO_WREG, OP_TRANSFER_WREG_TO_MEM,
		OP_OR_MEM_TO_WREG, OP_OR_IMM_TO_WREG, OP_OR_TO_MEM,
		OP_CALL_EXIT, OP_CALL_EXIT_IMM, OP_IRQ_EXIT,
		OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WREG,
		OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_WREG,
		OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_WREG,
		OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG,
		OP_LAST
	} ces_op_t;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE, ST_EXEC, ST_DUMMY, ST_IRQ
	} ces_state_t;

endpackage : ces_pkg

// file: ces_core.sv
// Execution datapath for a subset of an 8-bit core, with an AXI4-Lite register port.
// What this block does
// - Memory clear writes zero, flags untouched.
// - Bit clear zeroes one bit, keeps others.
// - Watchdog clear resets counter, timeout, powerdown.
// - Sleep halts, clears watchdog, sets powerdown.
// - Complement inverts byte, updates zero flag.
// - Working-register forms leave memory untouched.
// - BCD adjust adds six per nibble.
// - BCD adjust writes memory, changes carry only.
// - Minus-one subtracts one, updates zero.
// - Plus-one adds one, updates zero.
// - Goto loads address, takes two cycles.
// - Transfers copy data, flags untouched.
// - Idle op only advances program counter.
// - OR updates zero, to register or memory.
// - Returns pop counter; immediate form loads register.
// - Interrupt exit sets enable; with one pending, clears enable and takes it.
// - Rotate left moves bit 7 to 0.
// - Rotate left through carry swaps carry, bit 7.
// - Rotate right moves bit 0 to 7.
// - Rotate right through carry swaps carry, bit 0.
// - Counter-changing instructions take two cycles, three when interrupt exit takes a pending one.
module ces_core #(
	parameter int MEM_DEPTH = 256,
	parameter int PC_W = 13,
	parameter int STACK_DEPTH = 8,
	parameter int DOG_W = 8,
	parameter int PRESC_W = 8,
	parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address channel.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address channel.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Power control.
	output logic clock_gate_off
);

	localparam int MA_W = $clog2(MEM_DEPTH);
	localparam int SP_W = $clog2(STACK_DEPTH);

	// Zero test used wherever the zero flag is affected.
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	// Byte-lane merge of a write into an existing word.
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		strb_merge = r;
	endfunction : strb_merge

	// Architectural state.
	logic [7:0] mem [MEM_DEPTH]; // Data memory.
	logic [PC_W-1:0] stack_mem [STACK_DEPTH]; // Return stack.
	logic [SP_W-1:0] sp_reg; // Next free stack slot.
	logic [7:0] working_register;
	logic [PC_W-1:0] pc_reg;
	logic carry_flag, half_carry_flag, zero_flag;
	logic timeout_flag, powerdown_flag, global_irq_enable, irq_pending;
	logic asleep_reg; // Core halted with its clock gated.
	logic illegal_reg; // Last issued code was not recognised.
	logic [DOG_W-1:0] watchdog_counter;
	logic [PRESC_W-1:0] presc_reg;
	ces_pkg::ces_state_t state_reg;

	// Latched instruction.
	ces_pkg::ces_op_t op_reg;
	logic [2:0] bit_reg;
	logic [7:0] maddr_reg;
	logic [31:0] operand_reg; // Immediate in low byte, jump target in low bits.
	logic [31:0] mem_addr_reg; // Software window into data memory.

	// AXI write side holding registers.
	logic aw_full, w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_full && w_full && !s_axi_bvalid;

	// Decoded register hits for the pending write.
	logic wr_instr, wr_operand, wr_flags, wr_maddr, wr_mdata, wr_wake, wr_ok;
	always_comb begin
		wr_instr = wr_fire && aw_addr == ces_pkg::OFF_INSTR;
		wr_operand = wr_fire && aw_addr == ces_pkg::OFF_OPERAND;
		wr_flags = wr_fire && aw_addr == ces_pkg::OFF_FLAGS;
		wr_maddr = wr_fire && aw_addr == ces_pkg::OFF_MEM_ADDR;
		wr_mdata = wr_fire && aw_addr == ces_pkg::OFF_MEM_DATA;
		wr_wake = wr_fire && aw_addr == ces_pkg::OFF_WAKE;
		wr_ok = wr_instr || wr_operand || wr_flags || wr_maddr || wr_mdata || wr_wake;
	end

	// Write address and data are taken independently and held until used.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full <= 1'b0;
			end
		end
	end

	// Write response follows once both halves were used.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ces_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? ces_pkg::RESP_OKAY : ces_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Plain software registers: operand and memory window address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			operand_reg <= 32'h0000_0000;
			mem_addr_reg <= 32'h0000_0000;
		end else begin
			if (wr_operand) begin
				operand_reg <= strb_merge(operand_reg, w_data, w_strb);
			end
			if (wr_maddr) begin
				mem_addr_reg <= strb_merge(mem_addr_reg, w_data, w_strb);
			end
		end
	end

	// Flag and status word assembly.
	logic [ces_pkg::FLG_W-1:0] flags_word;
	always_comb begin
		flags_word = '0;
		flags_word[ces_pkg::FLG_CARRY] = carry_flag;
		flags_word[ces_pkg::FLG_HALF] = half_carry_flag;
		flags_word[ces_pkg::FLG_ZERO] = zero_flag;
		flags_word[ces_pkg::FLG_TIMEOUT] = timeout_flag;
		flags_word[ces_pkg::FLG_PDOWN] = powerdown_flag;
		flags_word[ces_pkg::FLG_GIE] = global_irq_enable;
		flags_word[ces_pkg::FLG_PEND] = irq_pending;
	end

	// Read data mux; unmapped offsets answer SLVERR with zero data.
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			ces_pkg::OFF_INSTR: rd_word = {8'h00, maddr_reg, 5'h00, bit_reg, 2'h0, op_reg};
			ces_pkg::OFF_OPERAND: rd_word = operand_reg;
			ces_pkg::OFF_STATUS: begin
				rd_word[7:0] = working_register;
				rd_word[ces_pkg::ST_FLAGS_LSB +: ces_pkg::FLG_W] = flags_word;
				rd_word[ces_pkg::ST_BUSY] = state_reg != ces_pkg::ST_IDLE;
				rd_word[ces_pkg::ST_ASLEEP] = asleep_reg;
				rd_word[ces_pkg::ST_ILLEGAL] = illegal_reg;
			end
			ces_pkg::OFF_FLAGS: rd_word[ces_pkg::FLG_W-1:0] = flags_word;
			ces_pkg::OFF_PC: rd_word[PC_W-1:0] = pc_reg;
			ces_pkg::OFF_MEM_ADDR: rd_word = mem_addr_reg;
			ces_pkg::OFF_MEM_DATA: rd_word[7:0] = mem[mem_addr_reg[MA_W-1:0]];
			ces_pkg::OFF_DOG: rd_word[DOG_W-1:0] = watchdog_counter;
			ces_pkg::OFF_WAKE: rd_word = 32'h0000_0000;
			default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: data one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ces_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? ces_pkg::RESP_OKAY : ces_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Instruction issue: only taken while idle and awake, else ignored.
	logic issue;
	assign issue = wr_instr && state_reg == ces_pkg::ST_IDLE && !asleep_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_reg <= ces_pkg::OP_IDLE_OP;
			bit_reg <= 3'h0;
			maddr_reg <= 8'h00;
			illegal_reg <= 1'b0;
		end else if (issue) begin
			bit_reg <= w_data[ces_pkg::INSTR_BIT_LSB +: 3];
			maddr_reg <= w_data[ces_pkg::INSTR_ADDR_LSB +: 8];
			if (w_data[ces_pkg::INSTR_OP_LSB +: ces_pkg::INSTR_OP_W] < ces_pkg::OP_LAST) begin
				op_reg <= ces_pkg::ces_op_t'(w_data[ces_pkg::INSTR_OP_LSB +: ces_pkg::INSTR_OP_W]);
				illegal_reg <= 1'b0;
			end else begin
				// Unknown codes run as an idle op.
				op_reg <= ces_pkg::OP_IDLE_OP;
				illegal_reg <= 1'b1;
			end
		end
	end

	// Datapath: one combinational step computes the instruction's data result and its write enables.
	logic [7:0] mval, imm, res;
	logic mem_we, wreg_we, z_we, c_we, c_val, pc_jump, pc_pop;
	logic [8:0] bcd_lo, bcd_sum;
	logic bcd_hi;
	always_comb begin
		mval = mem[maddr_reg[MA_W-1:0]];
		imm = operand_reg[7:0];
		res = 8'h00;
		mem_we = 1'b0;
		wreg_we = 1'b0;
		z_we = 1'b0;
		c_we = 1'b0;
		c_val = carry_flag;
		pc_jump = 1'b0;
		pc_pop = 1'b0;
		// Low nibble fix first, then the high nibble on the partly fixed sum.
		bcd_lo = {1'b0, working_register} +
			((working_register[3:0] > ces_pkg::BCD_MAX || half_carry_flag) ?
			ces_pkg::BCD_ADD_LO : 9'h000);
		bcd_hi = bcd_lo[7:4] > ces_pkg::BCD_MAX || bcd_lo[8] || carry_flag;
		bcd_sum = bcd_lo + (bcd_hi ? ces_pkg::BCD_ADD_HI : 9'h000);
		unique case (op_reg)
			ces_pkg::OP_CLEAR_MEM: begin
				res = 8'h00;
				mem_we = 1'b1;
			end
			ces_pkg::OP_CLEAR_BIT: begin
				res = mval & ~(8'h01 << bit_reg);
				mem_we = 1'b1;
			end
			ces_pkg::OP_COMPLEMENT_MEM: begin
				res = ~mval;
				mem_we = 1'b1;
				z_we = 1'b1;
			end
			ces_pkg::OP_COMPLEMENT_TO_WREG: begin
				res = ~mval;
				wreg_we = 1'b1;
				z_we = 1'b1;
			end
			ces_pkg::OP_BCD_ADJUST: begin
				res = bcd_sum[7:0];
				mem_we = 1'b1;
				c_we = 1'b1;
				c_val = bcd_hi;
			end
			ces_pkg::OP_MINUS_ONE_MEM, ces_pkg::OP_MINUS_ONE_TO_WREG: begin
				res = mval - 8'h01;
				mem_we = op_reg == ces_pkg::OP_MINUS_ONE_MEM;
				wreg_we = !mem_we;
				z_we = 1'b1;
			end
			ces_pkg::OP_PLUS_ONE_MEM, ces_pkg::OP_PLUS_ONE_TO_WREG: begin
				res = mval + 8'h01;
				mem_we = op_reg == ces_pkg::OP_PLUS_ONE_MEM;
				wreg_we = !mem_we;
				z_we = 1'b1;
			end
			ces_pkg::OP_GOTO_ADDR: pc_jump = 1'b1;
			ces_pkg::OP_TRANSFER_MEM_TO_WREG: begin
				res = mval;
				wreg_we = 1'b1;
			end
			ces_pkg::OP_TRANSFER_IMM_TO_WREG: begin
				res = imm;
				wreg_we = 1'b1;
			end
			ces_pkg::OP_TRANSFER_WREG_TO_MEM: begin
				res = working_register;
				mem_we = 1'b1;
			end
			ces_pkg::OP_OR_MEM_TO_WREG, ces_pkg::OP_OR_TO_MEM: begin
				res = working_register | mval;
				mem_we = op_reg == ces_pkg::OP_OR_TO_MEM;
				wreg_we = !mem_we;
				z_we = 1'b1;
			end
			ces_pkg::OP_OR_IMM_TO_WREG: begin
				res = working_register | imm;
				wreg_we = 1'b1;
				z_we = 1'b1;
			end
			ces_pkg::OP_CALL_EXIT, ces_pkg::OP_IRQ_EXIT: pc_pop = 1'b1;
			ces_pkg::OP_CALL_EXIT_IMM: begin
				pc_pop = 1'b1;
				res = imm;
				wreg_we = 1'b1;
			end
			ces_pkg::OP_ROTATE_LEFT, ces_pkg::OP_ROTATE_LEFT_TO_WREG: begin
				res = {mval[6:0], mval[7]};
				mem_we = op_reg == ces_pkg::OP_ROTATE_LEFT;
				wreg_we = !mem_we;
			end
			ces_pkg::OP_ROTATE_LEFT_THRU_CARRY, ces_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_WREG: begin
				res = {mval[6:0], carry_flag};
				mem_we = op_reg == ces_pkg::OP_ROTATE_LEFT_THRU_CARRY;
				wreg_we = !mem_we;
				c_we = 1'b1;
				c_val = mval[7];
			end
			ces_pkg::OP_ROTATE_RIGHT, ces_pkg::OP_ROTATE_RIGHT_TO_WREG: begin
				res = {mval[0], mval[7:1]};
				mem_we = op_reg == ces_pkg::OP_ROTATE_RIGHT;
				wreg_we = !mem_we;
			end
			ces_pkg::OP_ROTATE_RIGHT_THRU_CARRY, ces_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WREG: begin
				res = {carry_flag, mval[7:1]};
				mem_we = op_reg == ces_pkg::OP_ROTATE_RIGHT_THRU_CARRY;
				wreg_we = !mem_we;
				c_we = 1'b1;
				c_val = mval[0];
			end
			default: res = 8'h00; // Idle op, watchdog clear and sleep touch no data.
		endcase
	end

	// Sequencer: exec, then a dummy cycle when the counter is reloaded.
	logic take_irq;
	assign take_irq = op_reg == ces_pkg::OP_IRQ_EXIT && irq_pending;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ces_pkg::ST_IDLE;
		end else begin
			unique case (state_reg)
				ces_pkg::ST_IDLE: if (issue) state_reg <= ces_pkg::ST_EXEC;
				ces_pkg::ST_EXEC: state_reg <= (pc_jump || pc_pop) ?
					ces_pkg::ST_DUMMY : ces_pkg::ST_IDLE;
				ces_pkg::ST_DUMMY: state_reg <= take_irq ?
					ces_pkg::ST_IRQ : ces_pkg::ST_IDLE;
				ces_pkg::ST_IRQ: state_reg <= ces_pkg::ST_IDLE;
			endcase
		end
	end

	// Program counter and stack; a pending interrupt is entered before resuming.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_reg <= '0;
			sp_reg <= '0;
		end else if (state_reg == ces_pkg::ST_EXEC) begin
			if (pc_jump) begin
				pc_reg <= operand_reg[PC_W-1:0];
			end else if (pc_pop) begin
				pc_reg <= stack_mem[sp_reg - SP_W'(1)];
				sp_reg <= sp_reg - SP_W'(1);
			end else begin
				pc_reg <= pc_reg + PC_W'(1);
			end
		end else if (state_reg == ces_pkg::ST_IRQ) begin
			stack_mem[sp_reg] <= pc_reg;
			sp_reg <= sp_reg + SP_W'(1);
			pc_reg <= IRQ_VECTOR[PC_W-1:0];
		end
	end

	// Data memory: software window writes and instruction results.
	always_ff @(posedge aclk) begin
		if (state_reg == ces_pkg::ST_EXEC && mem_we) begin
			mem[maddr_reg[MA_W-1:0]] <= res;
		end else if (wr_mdata && w_strb[0]) begin
			mem[mem_addr_reg[MA_W-1:0]] <= w_data[7:0];
		end
	end

	// Working register and arithmetic flags.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			working_register <= ces_pkg::WREG_RST;
			carry_flag <= 1'b0;
			half_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
		end else if (state_reg == ces_pkg::ST_EXEC) begin
			if (wreg_we) working_register <= res;
			if (z_we) zero_flag <= is_zero(res);
			if (c_we) carry_flag <= c_val;
		end else if (wr_flags && w_strb[0]) begin
			carry_flag <= w_data[ces_pkg::FLG_CARRY];
			half_carry_flag <= w_data[ces_pkg::FLG_HALF];
			zero_flag <= w_data[ces_pkg::FLG_ZERO];
		end
	end

	// Power, watchdog and interrupt flags.
	logic exec_clrwdt, exec_sleep, dog_tick;
	assign exec_clrwdt = state_reg == ces_pkg::ST_EXEC && op_reg == ces_pkg::OP_CLEAR_WATCHDOG;
	assign exec_sleep = state_reg == ces_pkg::ST_EXEC && op_reg == ces_pkg::OP_SLEEP_ENTRY;
	assign dog_tick = presc_reg == '1;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag <= 1'b0;
			powerdown_flag <= 1'b0;
			global_irq_enable <= 1'b0;
			irq_pending <= 1'b0;
			asleep_reg <= 1'b0;
		end else begin
			if (exec_clrwdt) begin
				timeout_flag <= 1'b0;
				powerdown_flag <= 1'b0;
			end else if (exec_sleep) begin
				timeout_flag <= 1'b0;
				powerdown_flag <= 1'b1;
			end else if (dog_tick && watchdog_counter == '1 && !asleep_reg) begin
				timeout_flag <= 1'b1;
			end else if (wr_flags && w_strb[0]) begin
				timeout_flag <= w_data[ces_pkg::FLG_TIMEOUT];
				powerdown_flag <= w_data[ces_pkg::FLG_PDOWN];
			end
			if (exec_sleep) begin
				asleep_reg <= 1'b1;
			end else if (wr_wake) begin
				asleep_reg <= 1'b0;
			end
			if (state_reg == ces_pkg::ST_DUMMY && op_reg == ces_pkg::OP_IRQ_EXIT) begin
				global_irq_enable <= !irq_pending;
			end else if (wr_flags && w_strb[0]) begin
				global_irq_enable <= w_data[ces_pkg::FLG_GIE];
			end
			// Hardware entering the service routine wins over a software write.
			if (state_reg == ces_pkg::ST_IRQ) begin
				irq_pending <= 1'b0;
			end else if (wr_flags && w_strb[0]) begin
				irq_pending <= w_data[ces_pkg::FLG_PEND];
			end
		end
	end

	// Watchdog counter and its prescaler; frozen while asleep.
	always_ff @(posedge aclk) begin
		if (!aresetn || exec_clrwdt || exec_sleep) begin
			presc_reg <= '0;
			watchdog_counter <= '0;
		end else if (!asleep_reg) begin
			presc_reg <= presc_reg + PRESC_W'(1);
			if (dog_tick) watchdog_counter <= watchdog_counter + DOG_W'(1);
		end
	end

	// The core clock is gated off while asleep.
	assign clock_gate_off = asleep_reg;

endmodule : ces_core

// file: ces_core_monitor.sv
// Checker that watches the execution block's bus handshakes and clock gating.
module ces_core_monitor (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels.
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Power control.
	input wire logic clock_gate_off
);
	// All checks run on the bus clock; all but a_reset_quiet pause while reset is low.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not on second cycle");
	a_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
		&& !clock_gate_off)
		else $error("outputs busy after reset");
	a_gate_cause: assert property ($rose(clock_gate_off) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("clock gated without an issued instruction");
	// Main scenarios reached by the bench.
	c_gated: cover property (clock_gate_off);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ces_core_monitor

// Attach the checker to every instance of the core.
bind ces_core ces_core_monitor mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .clock_gate_off(clock_gate_off));

// file: cpu_instruction_execution_subset_tb.sv
// Self-checking bench for the instruction execution subset block.
module cpu_instruction_execution_subset_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Signals driven by the bench.
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	// Signals driven by the core.
	logic awready, wready, bvalid, arready, rvalid, gate_off;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, st, first, d;
	logic [7:0] op, bi, mi, ai, fi, im, em, ea, ef;
	logic [12:0] pc_exp = 13'h0;
	int bad_count = 0, comparisons = 0, cycles = 0;
	// Rows: opcode, bit, memory in, wreg in, flags in, operand, memory, wreg, flags out.
	localparam logic [71:0] ROWS [27] = '{
		72'h01_00_a5_3c_07_00_00_3c_07, 72'h02_07_ff_00_00_00_7f_00_00,
		72'h03_00_11_00_1b_00_11_00_03, 72'h04_00_ff_00_00_00_00_00_04,
		72'h05_00_0f_00_04_00_0f_f0_00, 72'h06_00_33_9a_00_00_00_9a_01,
		72'h06_00_33_12_06_00_18_12_06, 72'h06_00_33_15_01_00_75_15_01,
		72'h07_00_01_00_00_00_00_00_04, 72'h08_00_00_00_04_00_00_ff_00,
		72'h0a_00_ff_00_00_00_00_00_04, 72'h0b_00_7f_00_04_00_7f_80_00,
		72'h0d_00_3c_00_07_00_3c_3c_07, 72'h0e_00_11_00_07_c3_11_c3_07,
		72'h0f_00_11_5a_07_00_5a_5a_07, 72'h10_00_00_00_00_00_00_00_04,
		72'h11_00_00_10_04_01_00_11_00, 72'h12_00_0f_f0_04_00_ff_f0_00,
		72'h16_00_81_00_07_00_03_00_07, 72'h17_00_80_00_00_00_80_01_00,
		72'h18_00_80_00_00_00_00_00_01, 72'h19_00_01_00_01_00_01_03_00,
		72'h1a_00_01_00_07_00_80_00_07, 72'h1b_00_02_00_00_00_02_01_00,
		72'h1c_00_01_00_00_00_00_00_01, 72'h1d_00_80_00_01_00_80_c0_00,
		72'h00_00_5a_a5_07_00_5a_a5_07};

	ces_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.clock_gate_off(gate_off));

	// Clock at 20 MHz.
	always #25 aclk = ~aclk;

	// Counts one comparison and reports a mismatch.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// One bus write; both halves offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				done = 1'b1;
				rsp = bresp;
			end
		end
	endtask : wr

	// One bus read.
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata;
		rsp = rresp;
	endtask : rd

	// Writes a byte register.
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		wr(a, {24'h0, v});
	endtask : put

	// Issues one instruction at memory byte 2a and polls until it is done.
	task automatic run(input logic [7:0] code, input logic [7:0] b);
		wr(ces_pkg::OFF_INSTR, {8'h00, 8'h2a, b, code});
		pc_exp = pc_exp + 13'h1;
		rd(ces_pkg::OFF_STATUS, first);
		st = first;
		while (st[ces_pkg::ST_BUSY] !== 1'b0) rd(ces_pkg::OFF_STATUS, st);
	endtask : run

	// Prints the counts and the verdict, then stops.
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// Cuts a hung run short.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		put(ces_pkg::OFF_MEM_ADDR, 8'h2a);
		chk("okay response", 32'(ces_pkg::RESP_OKAY), 32'(rsp));
		for (int i = 0; i < 27; i++) begin
			{op, bi, mi, ai, fi, im, em, ea, ef} = ROWS[i];
			put(ces_pkg::OFF_MEM_DATA, mi);
			put(ces_pkg::OFF_OPERAND, ai);
			run(8'h0e, 8'h00);
			put(ces_pkg::OFF_FLAGS, fi);
			put(ces_pkg::OFF_OPERAND, im);
			run(op, bi);
			chk("wreg", 32'(ea), 32'(st[7:0]));
			chk("flags", 32'(ef), 32'(st[14:8]));
			rd(ces_pkg::OFF_MEM_DATA, d);
			chk("memory", 32'(em), d);
			rd(ces_pkg::OFF_PC, d);
			chk("pc", 32'(pc_exp), d);
		end
		// Goto and the exits hold busy for a dummy cycle.
		wr(ces_pkg::OFF_OPERAND, 32'h1234);
		run(8'h0c, 8'h00);
		chk("goto busy", 32'h1, 32'(first[ces_pkg::ST_BUSY]));
		rd(ces_pkg::OFF_PC, d);
		chk("goto pc", 32'h1234, d);
		put(ces_pkg::OFF_FLAGS, 8'h40);
		run(8'h15, 8'h00);
		chk("irq busy", 32'h1, 32'(first[ces_pkg::ST_BUSY]));
		chk("irq flags", 32'h0, 32'(st[14:8]));
		rd(ces_pkg::OFF_PC, d);
		chk("irq pc", 32'h4, d);
		put(ces_pkg::OFF_OPERAND, 8'ha5);
		put(ces_pkg::OFF_FLAGS, 8'h07);
		run(8'h14, 8'h00);
		chk("exit busy", 32'h1, 32'(first[ces_pkg::ST_BUSY]));
		chk("exit wreg", 32'ha5, 32'(st[7:0]));
		chk("exit flags", 32'h7, 32'(st[14:8]));
		run(8'h13, 8'h00);
		chk("plain exit flags", 32'h7, 32'(st[14:8]));
		put(ces_pkg::OFF_FLAGS, 8'h00);
		run(8'h15, 8'h00);
		chk("irq enable", 32'h20, 32'(st[14:8]));
		// Sleep gates the clock and ignores instructions until woken.
		put(ces_pkg::OFF_FLAGS, 8'h08);
		run(8'h09, 8'h00);
		chk("sleep flags", 32'h10, 32'(st[14:8]));
		chk("gate", 32'h1, 32'(gate_off));
		wr(ces_pkg::OFF_INSTR, 32'h002a_000d);
		rd(ces_pkg::OFF_STATUS, d);
		chk("asleep wreg", 32'ha5, 32'(d[7:0]));
		wr(ces_pkg::OFF_WAKE, 32'h1);
		rd(ces_pkg::OFF_STATUS, d);
		chk("woken", 32'h0, 32'(gate_off));
		// An unknown code, an unmapped write, then a reset in mid-run.
		run(8'h3f, 8'h00);
		chk("illegal", 32'h1, 32'(st[ces_pkg::ST_ILLEGAL]));
		wr(8'h24, 32'hffff);
		chk("unmapped", 32'(ces_pkg::RESP_SLVERR), 32'(rsp));
		rd(8'h24, d);
		chk("unmapped read", 32'(ces_pkg::RESP_SLVERR), 32'(rsp));
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ces_pkg::OFF_STATUS, d);
		chk("reset status", 32'h0, d);
		rd(ces_pkg::OFF_PC, d);
		chk("reset pc", 32'h0, d);
		test_done();
	end
endmodule : cpu_instruction_execution_subset_tb
